//--- verilog/slsf_top.sv
// APB slave exposing paged per-lane deskew and disparity status flags.
// Assumes zero-wait APB master on pclk and lane inputs synchronous to pclk.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "slsf_defs.svh"

module slsf_top #(
    parameter int NUM_LINKS = 2,
    parameter int NUM_LANES = 8,
    parameter int CNT_W     = 8,
    parameter int PAGE_W    = 1
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire slsf_pkg::slsf_addr_t                 paddr,
    input  wire slsf_pkg::slsf_word_t                 pwdata,
    output slsf_pkg::slsf_word_t                      prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic [NUM_LINKS*NUM_LANES-1:0]       lane_deskew_ok,
    input  wire logic [NUM_LINKS*NUM_LANES*CNT_W-1:0] lane_err_count
);
    import slsf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Per-link flag logic.

    logic [NUM_LINKS*NUM_LANES-1:0] align_all;
    logic [NUM_LINKS*NUM_LANES-1:0] disp_all;
    logic [CNT_W-1:0]               thresh_q;
    logic [PAGE_W-1:0]              page_q;

    genvar l;
    generate
        for (l = 0; l < NUM_LINKS; l++) begin : g_link
            slsf_lane_flags #(
                .NUM_LANES (NUM_LANES),
                .CNT_W     (CNT_W)
            ) u_flags (
                .pclk             (pclk),
                .presetn          (presetn),
                .deskew_ok        (lane_deskew_ok[l*NUM_LANES +: NUM_LANES]),
                .err_count        (lane_err_count[l*NUM_LANES*CNT_W +: NUM_LANES*CNT_W]),
                .error_threshold  (thresh_q),
                .align_ok_q       (align_all[l*NUM_LANES +: NUM_LANES]),
                .disparity_flag_q (disp_all[l*NUM_LANES +: NUM_LANES])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Page selection; a page with no link behind it reads as zero.

    logic [NUM_LANES-1:0] align_sel;
    logic [NUM_LANES-1:0] disp_sel;

    always_comb begin
        align_sel = '0;
        disp_sel  = '0;
        if (int'(page_q) < NUM_LINKS) begin
            align_sel = align_all[int'(page_q)*NUM_LANES +: NUM_LANES];
            disp_sel  = disp_all[int'(page_q)*NUM_LANES +: NUM_LANES];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    slsf_reg_t reg_sel;
    logic      setup;
    logic      access;

    // Every access completes in one cycle; the status path never stalls the bus.
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;

    always_comb begin
        unique case (paddr)
            `SLSF_PAGE_ADDR:   reg_sel = SLSF_REG_PAGE;
            `SLSF_DESKEW_ADDR: reg_sel = SLSF_REG_DESKEW;
            `SLSF_DISP_ADDR:   reg_sel = SLSF_REG_DISP;
            `SLSF_THRESH_ADDR: reg_sel = SLSF_REG_THRESH;
            default:           reg_sel = SLSF_REG_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writable control registers. Status addresses have no write path.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= PAGE_W'(`SLSF_PAGE_RST);
        end else if (access && pwrite && reg_sel == SLSF_REG_PAGE) begin
            page_q <= pwdata[`SLSF_PAGE_LSB +: PAGE_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thresh_q <= CNT_W'(`SLSF_THRESH_RST);
        end else if (access && pwrite && reg_sel == SLSF_REG_THRESH) begin
            thresh_q <= pwdata[`SLSF_THRESH_LSB +: CNT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and error are captured in the setup cycle so they are steady
    // from flip-flops for the whole access phase.

    slsf_word_t prdata_q;
    logic       pslverr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= '0;
            pslverr_q <= (reg_sel == SLSF_REG_NONE);
            if (!pwrite) begin
                unique case (reg_sel)
                    SLSF_REG_PAGE:   prdata_q[`SLSF_PAGE_LSB +: PAGE_W] <= page_q;
                    SLSF_REG_DESKEW: prdata_q[NUM_LANES-1:0] <= align_sel;
                    SLSF_REG_DISP:   prdata_q[NUM_LANES-1:0] <= disp_sel;
                    SLSF_REG_THRESH: prdata_q[`SLSF_THRESH_LSB +: CNT_W] <= thresh_q;
                    SLSF_REG_NONE:   prdata_q <= '0;
                endcase
            end
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && access;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    deskew_read_a: assert property (
        setup && !pwrite && reg_sel == SLSF_REG_DESKEW
        |=> prdata[NUM_LANES-1:0] == $past(align_sel))
        else $error("alignment status read does not match selected link");

    disp_thresh_a: assert property (
        $past(presetn) && $past(thresh_q == '0) |-> (&disp_all))
        else $error("disparity flag low with zero threshold");

    page_select_a: assert property (
        setup && !pwrite && reg_sel == SLSF_REG_DISP && int'(page_q) < NUM_LINKS
        |=> prdata[NUM_LANES-1:0] ==
            $past(disp_all[int'(page_q)*NUM_LANES +: NUM_LANES]))
        else $error("disparity read not taken from selected page");

    status_ro_a: assert property (
        access && pwrite && (reg_sel == SLSF_REG_DESKEW || reg_sel == SLSF_REG_DISP)
        |-> !pslverr ##1 ($stable(page_q) && $stable(thresh_q)))
        else $error("write to status register changed state or errored");

    deskew_width_a: assert property (
        setup && reg_sel == SLSF_REG_DESKEW
        |=> prdata[31:NUM_LANES] == '0)
        else $error("alignment status upper bits not zero");

    unmapped_err_a: assert property (
        setup && reg_sel == SLSF_REG_NONE |=> pslverr && prdata == '0)
        else $error("unmapped access not answered with error");

    page_write_a: assert property (
        access && pwrite && reg_sel == SLSF_REG_PAGE
        |=> page_q == $past(pwdata[`SLSF_PAGE_LSB +: PAGE_W]))
        else $error("page write did not land");

    page_read_a: assert property (
        setup && !pwrite && reg_sel == SLSF_REG_PAGE
        |=> prdata == 32'($past(page_q)))
        else $error("page read does not return the page register");

    thresh_write_a: assert property (
        access && pwrite && reg_sel == SLSF_REG_THRESH
        |=> thresh_q == $past(pwdata[`SLSF_THRESH_LSB +: CNT_W]))
        else $error("threshold write did not land");

    // Flags must leave reset at zero even while the lanes already report state.
    reset_flags_a: assert property (
        $rose(presetn) |-> align_all == '0 && disp_all == '0 && prdata == '0)
        else $error("status flags not zero on leaving reset");

    ////////////////////////////////////////////////////////////////////////////
    // Per-lane checks of every link, so that a lane swap in the flag module shows.

    genvar c;
    generate
        for (c = 0; c < NUM_LINKS*NUM_LANES; c++) begin : g_lane_chk
            lane_align_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                $past(presetn) |-> align_all[c] == $past(lane_deskew_ok[c]))
                else $error("alignment flag does not follow its lane");

            lane_disp_a: assert property (
                @(posedge pclk) disable iff (!presetn)
                $past(presetn)
                |-> disp_all[c] == $past(lane_err_count[c*CNT_W +: CNT_W] >= thresh_q))
                else $error("disparity flag does not follow the threshold compare");
        end
    endgenerate

    read_deskew_c: cover property (access && !pwrite && reg_sel == SLSF_REG_DESKEW);
    read_disp_c:   cover property (access && !pwrite && reg_sel == SLSF_REG_DISP && page_q != '0);
    write_thr_c:   cover property (access && pwrite && reg_sel == SLSF_REG_THRESH);
    unmapped_c:    cover property (access && reg_sel == SLSF_REG_NONE && pslverr);
    reset_exit_c:  cover property ($rose(presetn));

endmodule : slsf_top

//--- verilog/slsf_defs.svh
// Register indices, field positions and reset values of the lane status flags.
// Assumes the includer wants plain `define constants; no logic lives here.
`ifndef SLSF_DEFS_SVH
`define SLSF_DEFS_SVH

// Printed offsets are register indices; the APB byte address is four times the index.
`define SLSF_PAGE_IDX      16'h0300
`define SLSF_DESKEW_IDX    16'h046c
`define SLSF_DISP_IDX      16'h046d
`define SLSF_THRESH_IDX    16'h04f0
`define SLSF_PAGE_ADDR     (`SLSF_PAGE_IDX << 2)
`define SLSF_DESKEW_ADDR   (`SLSF_DESKEW_IDX << 2)
`define SLSF_DISP_ADDR     (`SLSF_DISP_IDX << 2)
`define SLSF_THRESH_ADDR   (`SLSF_THRESH_IDX << 2)

// Field positions and reset values.
`define SLSF_PAGE_LSB      0
`define SLSF_THRESH_LSB    0
`define SLSF_PAGE_RST      8'h00
`define SLSF_THRESH_RST    8'h00
`define SLSF_FLAGS_RST     8'h00

`endif

//--- verilog/slsf_pkg.sv
// Types shared by the lane status flag block.
// Assumes the constants header is included by the files that need numbers.
package slsf_pkg;

    typedef logic [31:0] slsf_word_t;
    typedef logic [15:0] slsf_addr_t;

    typedef enum logic [2:0] {
        SLSF_REG_NONE   = 3'b000,
        SLSF_REG_PAGE   = 3'b001,
        SLSF_REG_DESKEW = 3'b010,
        SLSF_REG_DISP   = 3'b011,
        SLSF_REG_THRESH = 3'b100
    } slsf_reg_t;

endpackage : slsf_pkg

//--- verilog/slsf_lane_flags.sv
// Per-lane status flags of one link: alignment result and disparity threshold flag.
// Assumes counts and deskew results arrive synchronous to pclk.
`timescale 1ns/1ps
`include "slsf_defs.svh"

module slsf_lane_flags #(
    parameter int NUM_LANES = 8,
    parameter int CNT_W     = 8
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [NUM_LANES-1:0]       deskew_ok,
    input  wire logic [NUM_LANES*CNT_W-1:0] err_count,
    input  wire logic [CNT_W-1:0]           error_threshold,
    output logic      [NUM_LANES-1:0]       align_ok_q,
    output logic      [NUM_LANES-1:0]       disparity_flag_q
);
    import slsf_pkg::*;

    genvar i;
    generate
        for (i = 0; i < NUM_LANES; i++) begin : g_lane
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    align_ok_q[i]       <= 1'b0;
                    disparity_flag_q[i] <= 1'b0;
                end else begin
                    align_ok_q[i]       <= deskew_ok[i];
                    disparity_flag_q[i] <= (err_count[i*CNT_W +: CNT_W] >= error_threshold);
                end
            end
        end
    endgenerate

endmodule : slsf_lane_flags

//--- verification/slsf_lane_src.sv
////////////////////////////////////////////////////////////////////////////////
// Behavioural model of the lane receiver logic that feeds the lane status inputs.
// It assumes the bench sets the wanted lane state and that the lane state changes on pclk.
`timescale 1ns/1ps

module slsf_lane_src (
    input  wire logic         pclk,
    input  wire logic [15:0]  want_ok,
    input  wire logic [127:0] want_cnt,
    output logic      [15:0]  lane_deskew_ok,
    output logic      [127:0] lane_err_count
);
    initial begin
        lane_deskew_ok = 16'h0000;
        lane_err_count = '0;
    end

    // The lane state is launched on the clock, as the receiver's own logic would see it.
    always @(posedge pclk) begin
        lane_deskew_ok <= want_ok;
        lane_err_count <= want_cnt;
    end
endmodule : slsf_lane_src

//--- verification/test_serial_lane_status_flags.sv
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the paged lane status flags, driven over APB.
// It assumes the lane model and the design files are compiled before it.
`timescale 1ns/1ps
`include "slsf_defs.svh"

module test_serial_lane_status_flags;
    import slsf_pkg::*;
    logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    slsf_addr_t paddr;
    slsf_word_t pwdata, prdata, rd;
    logic [15:0]  want_ok, lane_deskew_ok;
    logic [127:0] want_cnt, lane_err_count;
    int         error_cnt = 0, compares = 0, cycles = 0;

    slsf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lane_deskew_ok(lane_deskew_ok), .lane_err_count(lane_err_count));
    slsf_lane_src u_src (.pclk(pclk), .want_ok(want_ok), .want_cnt(want_cnt),
        .lane_deskew_ok(lane_deskew_ok), .lane_err_count(lane_err_count));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task summarize;
        if (error_cnt == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    task chk(input slsf_word_t got, input slsf_word_t exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input slsf_addr_t a, input slsf_word_t d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Lane i of the sixteen gets count base + step * i.
    function automatic logic [127:0] mk(input logic [7:0] base, input logic [7:0] step);
        logic [127:0] r;
        for (int i = 0; i < 16; i++) r[i*8 +: 8] = base + step * i[7:0];
        return r;
    endfunction : mk

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; want_ok = 16'h0000; want_cnt = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SLSF_PAGE_ADDR, 32'h0);       chk(rd, 32'h0);
        want_ok  <= 16'h3ca5;
        want_cnt <= mk(8'h00, 8'h02);
        repeat (3) @(posedge pclk);
        apb(1'b0, `SLSF_DESKEW_ADDR, 32'h0);     chk(rd, 32'ha5);
        apb(1'b0, `SLSF_DISP_ADDR, 32'h0);       chk(rd, 32'hff);
        apb(1'b1, `SLSF_THRESH_ADDR, 32'h0e);
        apb(1'b0, `SLSF_DISP_ADDR, 32'h0);       chk(rd, 32'h80);
        apb(1'b1, `SLSF_DESKEW_ADDR, 32'hff);    chk({31'h0, err}, 32'h0);
        apb(1'b0, `SLSF_DESKEW_ADDR, 32'h0);     chk(rd, 32'ha5);
        apb(1'b1, `SLSF_DISP_ADDR, 32'h7f);
        apb(1'b0, `SLSF_DISP_ADDR, 32'h0);       chk(rd, 32'h80);
        apb(1'b1, `SLSF_PAGE_ADDR, 32'h1);
        apb(1'b0, `SLSF_PAGE_ADDR, 32'h0);       chk(rd, 32'h1);
        apb(1'b0, `SLSF_DESKEW_ADDR, 32'h0);     chk(rd, 32'h3c);
        apb(1'b1, `SLSF_THRESH_ADDR, 32'h1c);
        apb(1'b0, `SLSF_DISP_ADDR, 32'h0);       chk(rd, 32'hc0);
        apb(1'b0, 16'h0ff0, 32'h0);              chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SLSF_PAGE_ADDR, 32'h0);       chk(rd, 32'h0);
        apb(1'b0, `SLSF_DISP_ADDR, 32'h0);       chk(rd, 32'hff);
        summarize();
    end
endmodule : test_serial_lane_status_flags
